// ==== logic/cepm_pkg.sv ====
// Purpose: shared constants and types of the pulse and monitor output block
// Assumes: word-wide classic Wishbone, register index = byte address / 4
// Notes: control registers are at most 8 bits wide in the low byte lane, except the 12-bit monitor address registers
package cepm_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_MON_CFG = 14'h2106;
  localparam logic [13:0] IDX_ACC_HI = 14'h2107;
  localparam logic [13:0] IDX_ACC_LO = 14'h2108;
  localparam logic [13:0] IDX_WIDTH = 14'h210A;
  localparam logic [13:0] IDX_SPACE = 14'h210B;
  localparam logic [13:0] IDX_POL = 14'h210C;
  localparam logic [13:0] IDX_OPT = 14'h2456;
  localparam logic [13:0] IDX_MADDR0 = 14'h2110;
  localparam logic [13:0] IDX_STATUS = 14'h2114;
  localparam logic [13:0] IDX_IRQ_EN = 14'h2115;
  // field positions
  localparam int MON_EN_BIT = 1;
  localparam int POL_BIT = 0;
  localparam int OPT_LSB = 2;
  localparam int ACC_HI_W = 5;
  // reset values
  localparam logic [7:0] WIDTH_RST = 8'hFF;
  localparam logic [7:0] SPACE_RST = 8'h00;
  localparam logic [12:0] ACC_RST = 13'h0888;
  localparam logic [7:0] NO_WIDTH_CHECK = 8'hFF;
  // timing
  localparam int SPACE_STEP = 4;
  localparam int CLK_NS = 20;
  localparam int MON_HALF_NS = 40;
  localparam int MON_HALF_CYC = (MON_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] MON_WORD_LAST = 6'h22;
  localparam logic [5:0] MON_DATA_BITS = 6'h20;
  localparam int MON_WORDS = 4;
  localparam int RAM_AW = 12;
  // optical transmit source
  typedef enum logic [1:0] {
    OPT_IDLE = 2'b00,
    OPT_W = 2'b01,
    OPT_V = 2'b10,
    OPT_IDLE2 = 2'b11
  } cepm_opt_e;
  // monitor sequencer
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_CAP = 2'b01,
    MS_SHIFT = 2'b10
  } cepm_mstate_e;
  // events from the compute engine
  typedef struct packed {
    logic frame_start;
    logic halt;
    logic wv_wr;
    logic w_sign;
    logic v_sign;
    logic xy_wr;
    logic x_val;
    logic y_val;
  } cepm_ce_s;
  // pins toward leds, optical port and test mux
  typedef struct packed {
    logic w_pin;
    logic v_pin;
    logic x_pin;
    logic y_pin;
    logic opt_pin;
    logic mon_data;
    logic mon_clk;
  } cepm_pins_s;
endpackage

// ==== logic/cepm_top.sv ====
// Purpose: pulse generators, paced energy pulse fifo, live sample monitor, frame/accumulation flags
// Assumes: compute engine signals are on clk; shared ram answers within the read strobe cycle, taken at the edge that closes it
// Notes:
// Overview of operation
// - capture four software-chosen shared ram words once per frame
// - shift monitored words out on test mux pin at each code pass start
// - monitor enable bit at index 0x2106 bit 1 switches monitor on/off
// - drive a separate shift clock on the second test mux pin
// - each monitor word spans 35 shift clocks and starts with a flag bit
// - monitor data stays low when no word is being sent
// - four pulse generators, each able to raise a processor interrupt
// - one polarity bit inverts all pulses; reset zero gives active low
// - status pulses update at most once per pass, on their own pins
// - energy pulse sign bits wait in an 8-bit fifo, released paced
// - fifo is emptied at every frame start
// - spacing register sets first delay and spacing of pulse updates
// - one spacing step equals four clock cycles
// - spacing zero bypasses the fifo, outputs update at once
// - width limit caps asserted pulse at (2*limit+1) update intervals
// - limit 255 or spacing zero disables width check, pulses follow engine
// - optical pin can carry either energy pulse via a select field
// - 13-bit accumulation length sets frames per accumulation cycle
// - raise accumulation done when an accumulation cycle completes
// - raise frame done at the end of every frame
// - halt instruction clears frame done and accumulation done
// - pulse interrupts fire on the leading edge only
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cepm_top
  import cepm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // compute engine side
  input wire cepm_pkg::cepm_ce_s ce_i,
  output logic [cepm_pkg::RAM_AW-1:0] ram_addr_o,
  output logic ram_rd_o,
  input wire logic [31:0] ram_rdata_i,
  // processor interrupt lines
  output logic [3:0] pulse_irq_o,
  output logic frame_done_irq_o,
  output logic accumulation_done_irq_o,
  // pins
  output cepm_pkg::cepm_pins_s pins_o
);
  import cepm_pkg::*;

  // msb-first bit of a monitor word at a position within its 35-cycle slot
  function automatic logic mon_bit(input logic [31:0] w, input logic [5:0] pos);
    logic [5:0] k;
    k = MON_DATA_BITS - pos;
    if (pos == 6'h00)
      mon_bit = 1'b1;
    else if (pos <= MON_DATA_BITS)
      mon_bit = w[k[4:0]];
    else
      mon_bit = 1'b0;
  endfunction

  // longest asserted width in cycles: (2*limit+1) * 4 * spacing
  function automatic logic [19:0] tmax_of(input logic [7:0] lim, input logic [7:0] sp);
    logic [9:0] odd;
    logic [29:0] prod;
    odd = {1'b0, lim, 1'b1};
    prod = 30'(odd) * 30'(sp) * 30'(SPACE_STEP);
    tmax_of = prod[19:0];
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic ack_q;
  logic [31:0] dat_q;
  logic mon_en_q;
  logic [12:0] acc_len_q;
  logic [7:0] width_q;
  logic [7:0] space_q;
  logic pol_q;
  logic [1:0] opt_q;
  logic [RAM_AW-1:0] maddr_q [MON_WORDS];
  logic [3:0] irq_en_q;
  logic req;
  logic wr;
  logic [31:0] rd_mux;
  logic [13:0] idx;
  logic frame_done_q;
  logic accum_done_q;
  logic [12:0] acc_cnt_q;
  logic [1:0] fifo_q [4];
  logic [1:0] wp_q;
  logic [1:0] rp_q;
  logic [2:0] cnt_q;
  logic [9:0] tmr_q;
  logic [9:0] ival;
  logic tick;
  logic bypass;
  logic [1:0] act_q;
  logic [1:0] upd;
  logic [1:0] cap_q;
  logic [19:0] wid_q [2];
  logic [19:0] tmax;
  logic check;
  logic [1:0] eff;
  logic x_act_q;
  logic y_act_q;
  logic xy_done_q;
  logic [3:0] prev_q;
  logic [3:0] pulse_irq_q;
  logic [3:0] pact;
  logic w_pin_q;
  logic v_pin_q;
  logic x_pin_q;
  logic y_pin_q;
  logic opt_pin_q;
  cepm_mstate_e ms_q;
  logic [2:0] cidx_q;
  logic rd_q;
  logic [1:0] ridx_q;
  logic [RAM_AW-1:0] raddr_q;
  logic [31:0] word_q [MON_WORDS];
  logic [1:0] widx_q;
  logic [5:0] pos_q;
  logic [1:0] div_q;
  logic sclk_q;
  logic mdat_q;

  assign idx = wb_adr_i[15:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];

  // read mux; unmapped indices read zero and still get an ack
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_MON_CFG: rd_mux[MON_EN_BIT] = mon_en_q;
      IDX_ACC_HI: rd_mux[ACC_HI_W-1:0] = acc_len_q[12:8];
      IDX_ACC_LO: rd_mux[7:0] = acc_len_q[7:0];
      IDX_WIDTH: rd_mux[7:0] = width_q;
      IDX_SPACE: rd_mux[7:0] = space_q;
      IDX_POL: rd_mux[POL_BIT] = pol_q;
      IDX_OPT: rd_mux[OPT_LSB+1:OPT_LSB] = opt_q;
      IDX_STATUS: rd_mux[5:0] = {pact, accum_done_q, frame_done_q};
      IDX_IRQ_EN: rd_mux[3:0] = irq_en_q;
      default:
      begin
        if (idx >= IDX_MADDR0 && idx < IDX_MADDR0 + 14'(MON_WORDS))
          rd_mux[RAM_AW-1:0] = maddr_q[2'(idx - IDX_MADDR0)];
      end
    endcase
  end

  // bus handshake: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      if (req)
        dat_q <= rd_mux;
    end
  end

  // register writes, gated by the low byte lane select; monitor addresses also take bits 11:8
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mon_en_q <= 1'b0;
      acc_len_q <= ACC_RST;
      width_q <= WIDTH_RST;
      space_q <= SPACE_RST;
      pol_q <= 1'b0;
      opt_q <= 2'b00;
      irq_en_q <= 4'h0;
      for (int i = 0; i < MON_WORDS; i++)
        maddr_q[i] <= 12'h000;
    end
    else if (wr)
    begin
      case (idx)
        IDX_MON_CFG: mon_en_q <= wb_dat_i[MON_EN_BIT];
        IDX_ACC_HI: acc_len_q[12:8] <= wb_dat_i[ACC_HI_W-1:0];
        IDX_ACC_LO: acc_len_q[7:0] <= wb_dat_i[7:0];
        IDX_WIDTH: width_q <= wb_dat_i[7:0];
        IDX_SPACE: space_q <= wb_dat_i[7:0];
        IDX_POL: pol_q <= wb_dat_i[POL_BIT];
        IDX_OPT: opt_q <= wb_dat_i[OPT_LSB+1:OPT_LSB];
        IDX_IRQ_EN: irq_en_q <= wb_dat_i[3:0];
        default:
        begin
          if (idx >= IDX_MADDR0 && idx < IDX_MADDR0 + 14'(MON_WORDS))
            maddr_q[2'(idx - IDX_MADDR0)] <= wb_dat_i[RAM_AW-1:0];
        end
      endcase
    end
  end

  // frame and accumulation flags; a new frame beats a halt in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_done_q <= 1'b0;
      accum_done_q <= 1'b0;
      acc_cnt_q <= 13'h0000;
    end
    else if (ce_i.frame_start)
    begin
      frame_done_q <= 1'b1;
      if (acc_cnt_q + 13'h0001 >= acc_len_q)
      begin
        acc_cnt_q <= 13'h0000;
        accum_done_q <= 1'b1;
      end
      else
        acc_cnt_q <= acc_cnt_q + 13'h0001;
    end
    else if (ce_i.halt)
    begin
      frame_done_q <= 1'b0;
      accum_done_q <= 1'b0;
    end
  end

  // update pacing: first release after 4*spacing cycles, then every 4*spacing
  assign ival = {space_q, 2'b00};
  assign tick = (space_q != 8'h00) && (tmr_q == ival - 10'h001);
  assign bypass = (space_q == 8'h00);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tmr_q <= 10'h000;
    else if (ce_i.frame_start || tick)
      tmr_q <= 10'h000;
    else
      tmr_q <= tmr_q + 10'h001;
  end

  // four two-bit entries; a full fifo drops the export, frame start empties it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q <= 2'b00;
      rp_q <= 2'b00;
      cnt_q <= 3'h0;
      for (int i = 0; i < 4; i++)
        fifo_q[i] <= 2'b00;
    end
    else if (ce_i.frame_start)
    begin
      wp_q <= 2'b00;
      rp_q <= 2'b00;
      cnt_q <= 3'h0;
    end
    else
    begin
      if (ce_i.wv_wr && !bypass && cnt_q != 3'h4)
      begin
        fifo_q[wp_q] <= {ce_i.v_sign, ce_i.w_sign};
        wp_q <= wp_q + 2'b01;
      end
      if (tick && cnt_q != 3'h0)
        rp_q <= rp_q + 2'b01;
      cnt_q <= cnt_q + 3'((ce_i.wv_wr && !bypass && cnt_q != 3'h4) ? 1 : 0)
        - 3'((tick && cnt_q != 3'h0) ? 1 : 0);
    end
  end

  // energy pulse levels; bit 0 is active energy, bit 1 reactive energy
  assign upd[0] = (bypass && ce_i.wv_wr) || (tick && cnt_q != 3'h0 && !ce_i.frame_start);
  assign upd[1] = upd[0];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      act_q <= 2'b00;
    else if (bypass && ce_i.wv_wr)
      act_q <= {ce_i.v_sign, ce_i.w_sign};
    else if (upd[0])
      act_q <= fifo_q[rp_q];
  end

  // width limiter: a long pulse is cut and held off until the next update
  assign check = !bypass && (width_q != NO_WIDTH_CHECK);
  assign tmax = tmax_of(width_q, space_q);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cap_q <= 2'b00;
      wid_q[0] <= 20'h0_0000;
      wid_q[1] <= 20'h0_0000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (upd[i])
        begin
          cap_q[i] <= 1'b0;
          wid_q[i] <= 20'h0_0000;
        end
        else if (check && act_q[i] && !cap_q[i])
        begin
          if (wid_q[i] + 20'h0_0001 >= tmax)
            cap_q[i] <= 1'b1;
          wid_q[i] <= wid_q[i] + 20'h0_0001;
        end
      end
    end
  end
  assign eff = act_q & ~(cap_q & {2{check}});

  // status pulses: first write of a pass wins, later ones are ignored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      x_act_q <= 1'b0;
      y_act_q <= 1'b0;
      xy_done_q <= 1'b0;
    end
    else
    begin
      if (ce_i.xy_wr && (!xy_done_q || ce_i.frame_start))
      begin
        x_act_q <= ce_i.x_val;
        y_act_q <= ce_i.y_val;
      end
      if (ce_i.frame_start)
        xy_done_q <= ce_i.xy_wr;
      else if (ce_i.xy_wr)
        xy_done_q <= 1'b1;
    end
  end

  // leading-edge interrupts, one cycle wide, per enabled generator
  assign pact = {y_act_q, x_act_q, eff};
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prev_q <= 4'h0;
      pulse_irq_q <= 4'h0;
    end
    else
    begin
      prev_q <= pact;
      pulse_irq_q <= pact & ~prev_q & irq_en_q;
    end
  end

  // pin drivers; polarity clear means an asserted pulse pulls the pin low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w_pin_q <= 1'b1;
      v_pin_q <= 1'b1;
      x_pin_q <= 1'b1;
      y_pin_q <= 1'b1;
      opt_pin_q <= 1'b1;
    end
    else
    begin
      w_pin_q <= eff[0] ~^ pol_q;
      v_pin_q <= eff[1] ~^ pol_q;
      x_pin_q <= x_act_q ~^ pol_q;
      y_pin_q <= y_act_q ~^ pol_q;
      case (cepm_opt_e'(opt_q))
        OPT_W: opt_pin_q <= eff[0] ~^ pol_q;
        OPT_V: opt_pin_q <= eff[1] ~^ pol_q;
        default: opt_pin_q <= ~pol_q;
      endcase
    end
  end

  // monitor: read four words at pass start, then shift them out
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_q <= MS_IDLE;
      cidx_q <= 3'h0;
      rd_q <= 1'b0;
      ridx_q <= 2'b00;
      raddr_q <= 12'h000;
      widx_q <= 2'b00;
      pos_q <= 6'h00;
      div_q <= 2'b00;
      sclk_q <= 1'b0;
      mdat_q <= 1'b0;
      for (int i = 0; i < MON_WORDS; i++)
        word_q[i] <= 32'h0000_0000;
    end
    else
    begin
      rd_q <= 1'b0;
      if (rd_q)
        word_q[ridx_q] <= ram_rdata_i;
      case (ms_q)
        MS_IDLE:
        begin
          sclk_q <= 1'b0;
          mdat_q <= 1'b0;
          if (ce_i.frame_start && mon_en_q)
          begin
            ms_q <= MS_CAP;
            cidx_q <= 3'h0;
          end
        end
        MS_CAP:
        begin
          if (!mon_en_q)
            ms_q <= MS_IDLE;
          else if (cidx_q != 3'(MON_WORDS))
          begin
            rd_q <= 1'b1;
            ridx_q <= cidx_q[1:0];
            raddr_q <= maddr_q[cidx_q[1:0]];
            cidx_q <= cidx_q + 3'h1;
          end
          else if (!rd_q)
          begin
            ms_q <= MS_SHIFT;
            widx_q <= 2'b00;
            pos_q <= 6'h00;
            div_q <= 2'b00;
            mdat_q <= 1'b1;
          end
        end
        MS_SHIFT:
        begin
          if (!mon_en_q)
          begin
            ms_q <= MS_IDLE;
            sclk_q <= 1'b0;
            mdat_q <= 1'b0;
          end
          else if (div_q == 2'(MON_HALF_CYC - 1))
          begin
            div_q <= 2'b00;
            sclk_q <= !sclk_q;
            if (sclk_q)
            begin
              if (pos_q == MON_WORD_LAST)
              begin
                pos_q <= 6'h00;
                if (widx_q == 2'(MON_WORDS - 1))
                begin
                  ms_q <= MS_IDLE;
                  mdat_q <= 1'b0;
                end
                else
                begin
                  widx_q <= widx_q + 2'b01;
                  mdat_q <= 1'b1;
                end
              end
              else
              begin
                pos_q <= pos_q + 6'h01;
                mdat_q <= mon_bit(word_q[widx_q], pos_q + 6'h01);
              end
            end
          end
          else
            div_q <= div_q + 2'b01;
        end
        default: ms_q <= MS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign ram_addr_o = raddr_q;
  assign ram_rd_o = rd_q;
  assign pulse_irq_o = pulse_irq_q;
  assign frame_done_irq_o = frame_done_q;
  assign accumulation_done_irq_o = accum_done_q;
  assign pins_o = '{w_pin: w_pin_q, v_pin: v_pin_q, x_pin: x_pin_q, y_pin: y_pin_q,
    opt_pin: opt_pin_q, mon_data: mdat_q, mon_clk: sclk_q};

  property p_mon_idle_low;
    (ms_q != MS_SHIFT) |=> (ms_q != MS_SHIFT) |-> (!mdat_q && !sclk_q);
  endproperty
  a_mon_idle_low: assert property (p_mon_idle_low) else $error("monitor pins not low while idle");

  property p_mon_flag;
    $rose(ms_q == MS_SHIFT) |-> mdat_q && !sclk_q;
  endproperty
  a_mon_flag: assert property (p_mon_flag) else $error("monitor word did not open with flag");

  property p_mon_off;
    (!mon_en_q && ms_q == MS_IDLE) |=> ms_q == MS_IDLE;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor started while disabled");

  property p_bypass;
    (bypass && ce_i.wv_wr) |=> act_q == $past({ce_i.v_sign, ce_i.w_sign});
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not update at once");

  property p_fifo_clear;
    ce_i.frame_start |=> cnt_q == 3'h0 && tmr_q == 10'h000;
  endproperty
  a_fifo_clear: assert property (p_fifo_clear) else $error("fifo not emptied at frame start");

  property p_step;
    (space_q == 8'h01 && !ce_i.frame_start && tmr_q == 10'h000 && $stable(space_q)) ##1
      (!ce_i.frame_start && $stable(space_q))[*2] |-> ##1 tick;
  endproperty
  a_step: assert property (p_step) else $error("spacing step is not four cycles");

  property p_xy_once;
    (xy_done_q && ce_i.xy_wr && !ce_i.frame_start) |=> $stable(x_act_q) && $stable(y_act_q);
  endproperty
  a_xy_once: assert property (p_xy_once) else $error("status pulse updated twice in a pass");

  property p_polarity;
    1'b1 |=> w_pin_q == ($past(pol_q) ? $past(eff[0]) : !$past(eff[0]));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pulse pin polarity wrong");

  property p_halt_clear;
    (ce_i.halt && !ce_i.frame_start) |=> !frame_done_q && !accum_done_q;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halt did not clear flags");

  property p_irq_edge;
    pulse_irq_q[0] |-> $past(eff[0]) && !$past(prev_q[0]);
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("interrupt without leading edge");

  property p_cap;
    (check && act_q[0] && !cap_q[0] && !upd[0] && wid_q[0] + 20'h0_0001 >= tmax) |=> cap_q[0] || upd[0];
  endproperty
  a_cap: assert property (p_cap) else $error("pulse not cut at width limit");
endmodule
`default_nettype wire

// ==== verification/cepm_partner.sv ====
// Purpose: shared ram and test equipment on the far side of the block
// Assumes: ram data is valid during the cycle of a read strobe and is taken at its closing edge
// Notes: the receiver samples monitor data on the rising shift clock
`timescale 1ns/1ns
`default_nettype none
module cepm_partner
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // shared ram
  input wire logic [11:0] ram_addr,
  input wire logic ram_rd,
  output logic [31:0] ram_rdata,
  // monitor pins and captured words
  input wire logic mon_data,
  input wire logic mon_clk,
  output logic [31:0] word,
  output logic word_ok
);
  logic clk_prev_q;
  logic [5:0] bit_q;
  // asynchronous read: data follows the address within the strobe cycle, since the block takes it at
  // the edge that closes that cycle; outside a read the bus shows the inverse so a stale word never passes
  always_comb
  begin
    if (ram_rd)
      ram_rdata = {ram_addr, ~ram_addr, 8'h3c};
    else
      ram_rdata = ~{ram_addr, ~ram_addr, 8'h3c};
  end
  // flag bit, 32 data bits msb first, two trailing bits: 35 shift clocks
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_prev_q <= 1'b0;
      bit_q <= 6'h00;
      word_ok <= 1'b0;
      word <= 32'h0000_0000;
    end
    else
    begin
      clk_prev_q <= mon_clk;
      word_ok <= 1'b0;
      if (mon_clk && !clk_prev_q)
      begin
        if (bit_q == 6'h00)
          bit_q <= {5'h00, mon_data};
        else if (bit_q == 6'h22)
        begin
          bit_q <= 6'h00;
          word_ok <= 1'b1;
        end
        else
        begin
          bit_q <= bit_q + 6'h01;
          if (bit_q <= 6'h20)
            word <= {word[30:0], mon_data};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/cepm_top_test.sv ====
// Purpose: self-checking bench for the pulse and monitor output block
// Assumes: 50 MHz clock, reset held low for 20 cycles
// Notes: read answers and monitor words are compared with queued notes
`timescale 1ns/1ns
`default_nettype none
module cepm_top_test;
  import cepm_pkg::*;
  logic clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack_o, ram_rd_o, frame_done_irq_o, accumulation_done_irq_o, word_ok;
  logic [15:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o, ram_rdata, word;
  logic [11:0] ram_addr_o, a;
  logic [3:0] pulse_irq_o;
  cepm_ce_s ce;
  cepm_pins_s pins_o;
  logic [31:0] rd_q[$], mon_q[$];
  int n_errors, checks_done, irq_w, words;
  integer seed = 32'h0000_79dd;
  wire [2:0] wvo = {pins_o.w_pin, pins_o.v_pin, pins_o.opt_pin};

  cepm_top dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ce_i(ce), .ram_addr_o(ram_addr_o), .ram_rd_o(ram_rd_o), .ram_rdata_i(ram_rdata),
    .pulse_irq_o(pulse_irq_o), .frame_done_irq_o(frame_done_irq_o),
    .accumulation_done_irq_o(accumulation_done_irq_o), .pins_o(pins_o));
  cepm_partner far (.clk(clk), .reset_n(reset_n), .ram_addr(ram_addr_o), .ram_rd(ram_rd_o),
    .ram_rdata(ram_rdata), .mon_data(pins_o.mon_data), .mon_clk(pins_o.mon_clk), .word(word), .word_ok(word_ok));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // classic cycle; bits above the widest register field (12) carry random junk the block must ignore
  task automatic bus(input logic we, input logic [13:0] idx, input logic [7:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_dat <= {20'($random(seed)), 4'h0, d};
    do
      @(posedge clk);
    while (wb_ack_o !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, idx, 8'h00);
  endtask

  // one-cycle engine event
  task automatic ce_evt(input logic [7:0] v);
    @(posedge clk);
    ce <= cepm_ce_s'(v);
    @(posedge clk);
    ce <= cepm_ce_s'(8'h00);
  endtask

  task automatic wait_chk(input int n, input string what, input logic [31:0] seen_sel, input logic [31:0] exp);
    repeat (n) @(posedge clk);
    #1;
    chk(what, seen_sel == 0 ? 32'(wvo) : seen_sel == 1 ? 32'(irq_w) : 32'(pins_o.w_pin), exp);
  endtask

  // count leading-edge w irqs, compare monitor words and read answers with the oldest notes
  always @(posedge clk)
  begin
    if (pulse_irq_o[0] === 1'b1)
      irq_w++;
    if (word_ok === 1'b1)
    begin
      words++;
      chk("monitor word", word, mon_q.pop_front());
    end
    if (wb_ack_o === 1'b1 && !wb_we)
      chk("read data", wb_dat_o, rd_q.pop_front());
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial
  begin
    reset_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 16'h0000;
    wb_dat = 32'h0000_0000;
    ce = cepm_ce_s'(8'h00);
    repeat (19) @(posedge clk);
    #1 chk("pins in reset", 32'(pins_o), 32'h0000_007c);
    @(posedge clk);
    reset_n <= 1'b1;
    rd(IDX_WIDTH, 32'h0000_00ff);
    rd(IDX_SPACE, 32'h0000_0000);
    rd(IDX_ACC_HI, 32'h0000_0008);
    rd(IDX_ACC_LO, 32'h0000_0088);
    rd(IDX_POL, 32'h0000_0000);
    rd(14'h3000, 32'h0000_0000);
    // spacing zero: pins follow the engine at once
    wr(IDX_IRQ_EN, 8'h0f);
    wr(IDX_OPT, 8'h04);
    ce_evt(8'h30);
    wait_chk(3, "w v opt pins", 0, 32'h0000_0002);
    ce_evt(8'h30);
    wait_chk(3, "w irq count", 1, 32'h0000_0001);
    wr(IDX_POL, 8'h01);
    wait_chk(3, "w v opt pins", 0, 32'h0000_0005);
    wr(IDX_OPT, 8'h08);
    wait_chk(3, "w v opt pins", 0, 32'h0000_0004);
    // only the first status update of a pass counts
    ce_evt(8'h80);
    ce_evt(8'h06);
    ce_evt(8'h04);
    repeat (3) @(posedge clk);
    #1 chk("x pin", 32'(pins_o.x_pin), 32'h0000_0001);
    wr(IDX_POL, 8'h00);
    ce_evt(8'h20);
    // paced fifo with 4-cycle interval; one update per frame is released well before the frame ends
    wr(IDX_SPACE, 8'h01);
    wr(IDX_WIDTH, 8'h00);
    ce_evt(8'h80);
    ce_evt(8'h30);
    // release lands 4 cycles after frame start; limit 0 cuts it after one interval
    wait_chk(2, "w pin before release", 2, 32'h0000_0001);
    wait_chk(2, "w pin released", 2, 32'h0000_0000);
    wait_chk(18, "w irq count", 1, 32'h0000_0002);
    wait_chk(0, "w pin after cut", 2, 32'h0000_0001);
    // frame start throws away unreleased entries
    ce_evt(8'h80);
    ce_evt(8'h30);
    ce_evt(8'h80);
    wait_chk(20, "w irq count", 1, 32'h0000_0002);
    wr(IDX_WIDTH, 8'hff);
    ce_evt(8'h80);
    ce_evt(8'h30);
    wait_chk(20, "w pin uncut", 2, 32'h0000_0000);
    // length 1: every frame ends an accumulation; halt clears both flags
    wr(IDX_ACC_HI, 8'h00);
    wr(IDX_ACC_LO, 8'h01);
    ce_evt(8'h80);
    repeat (2) @(posedge clk);
    #1 chk("flags", 32'({frame_done_irq_o, accumulation_done_irq_o}), 32'h0000_0003);
    ce_evt(8'h40);
    repeat (2) @(posedge clk);
    #1 chk("flags", 32'({frame_done_irq_o, accumulation_done_irq_o}), 32'h0000_0000);
    // monitor four random locations
    for (int i = 0; i < 4; i++)
    begin
      a = {4'h0, 8'($random(seed))};
      wr(IDX_MADDR0 + 14'(i), a[7:0]);
      mon_q.push_back({a, ~a, 8'h3c});
    end
    wr(IDX_MON_CFG, 8'h02);
    ce_evt(8'h80);
    repeat (700) @(posedge clk);
    #1 chk("monitor words", 32'(words), 32'h0000_0004);
    chk("monitor data idle", 32'(pins_o.mon_data), 32'h0000_0000);
    wr(IDX_MON_CFG, 8'h00);
    ce_evt(8'h80);
    repeat (300) @(posedge clk);
    #1 chk("monitor words", 32'(words), 32'h0000_0004);
    close_out();
  end
endmodule
`default_nettype wire
